/* core/swpc_top.sv */
// swpc_top: sleep and wake power controller with an avalon-mm register slave
// assumes: all inputs synchronous to clk; lf_clk is the 32 kHz clock seen as a level on clk
`timescale 1ns/1ps
`default_nettype none
module swpc_top
  import swpc_pkg::*;
#(
  parameter int unsigned N_SUBSYS = 4,
  parameter int unsigned TIMER_W = 24
) (
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // wake sources and activity
  input wire logic lf_clk,
  input wire logic gpio_wake,
  input wire logic comp_event,
  input wire logic rtc_timeout,
  input wire logic wdt_irq,
  input wire logic host_cmd_req,
  input wire logic host_cmd_done,
  input wire logic cpu_idle,
  input wire logic [N_SUBSYS-1:0] subsys_busy,
  // host interface type detection
  input wire logic host_if_det_valid,
  input wire logic [1:0] host_if_det_type,
  // power and clock controls
  output logic hf_clk_en,
  output logic cpu_clk_en,
  output logic host_if_clk_en,
  output logic [N_SUBSYS-1:0] subsys_pwr_en,
  output logic [N_SUBSYS-1:0] subsys_clk_en,
  output logic ram_retain,
  output logic aon_low_supply,
  output logic [1:0] host_if_sel,
  output logic host_if_sel_valid,
  output logic wake_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  swpc_state_type state_reg, state_next;
  logic [6:0] ctrl_reg;
  logic [SWPC_SRC_NUM-1:0] wake_en_reg;
  logic [TIMER_W-1:0] timeout_reg;
  logic [SWPC_SRC_NUM-1:0] irq_stat_reg;
  logic [SWPC_SRC_NUM-1:0] irq_mask_reg;
  logic [N_SUBSYS-1:0] subsys_en_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [7:0] pwr_cnt_reg;
  logic lf_prev_reg;
  logic enter_reg;
  logic [1:0] host_if_reg;
  logic host_if_valid_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;

  logic lf_tick;
  logic timer_exp;
  logic gpio_hit;
  logic [SWPC_SRC_NUM-1:0] src_raw;
  logic [SWPC_SRC_NUM-1:0] src_allowed;
  logic [SWPC_SRC_NUM-1:0] stat_clr;
  logic wake_any;
  logic bus_done;
  logic wr_en;
  logic rd_en;
  logic sleep_go;
  logic [1:0] tgt_mode;
  logic standby;

  ////////////////////////////////////////////////////////////////////////////
  // wake source qualification

  assign lf_tick = lf_clk & ~lf_prev_reg;
  assign timer_exp = (timer_reg == '0);
  assign gpio_hit = (gpio_wake == ctrl_reg[SWPC_CTRL_POL_BIT]);
  assign tgt_mode = ctrl_reg[SWPC_CTRL_MODE_LSB +: 2];
  assign standby = ctrl_reg[SWPC_CTRL_STANDBY_BIT];

  always_comb begin
    src_raw = '0;
    src_raw[SWPC_SRC_TIMER] = timer_exp;
    src_raw[SWPC_SRC_GPIO] = gpio_hit;
    src_raw[SWPC_SRC_COMP] = comp_event;
    src_raw[SWPC_SRC_RTC] = rtc_timeout;
    src_raw[SWPC_SRC_WDT] = wdt_irq;
    src_raw[SWPC_SRC_HOST] = host_cmd_req;
  end

  // each sleep mode listens only to its own sources
  always_comb begin
    src_allowed = '0;
    if (state_reg == SWPC_ST_DEEP) begin
      src_allowed = src_raw & wake_en_reg;
      src_allowed[SWPC_SRC_HOST] = 1'b0;
    end else if (state_reg == SWPC_ST_LIGHT) begin
      src_allowed[SWPC_SRC_TIMER] = src_raw[SWPC_SRC_TIMER] & wake_en_reg[SWPC_SRC_TIMER];
      src_allowed[SWPC_SRC_GPIO] = src_raw[SWPC_SRC_GPIO] & wake_en_reg[SWPC_SRC_GPIO];
      src_allowed[SWPC_SRC_HOST] = src_raw[SWPC_SRC_HOST];
    end
  end

  assign wake_any = |src_allowed;

  // sleep request from software, or on its own when the cpu is idle
  assign sleep_go = (enter_reg | (ctrl_reg[SWPC_CTRL_AUTO_BIT] & cpu_idle)) &
                    ((tgt_mode == SWPC_TGT_LIGHT) | (tgt_mode == SWPC_TGT_DEEP));

  ////////////////////////////////////////////////////////////////////////////
  // sleep state machine

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SWPC_ST_ACTIVE: begin
        if (sleep_go && tgt_mode == SWPC_TGT_DEEP) begin
          state_next = SWPC_ST_DEEP;
        end else if (sleep_go) begin
          state_next = SWPC_ST_LIGHT;
        end
      end
      SWPC_ST_LIGHT: begin
        if (src_allowed[SWPC_SRC_HOST]) begin
          state_next = SWPC_ST_SERVE;
        end else if (src_allowed[SWPC_SRC_TIMER] && standby) begin
          state_next = SWPC_ST_SERVE;
        end else if (wake_any) begin
          state_next = SWPC_ST_ACTIVE;
        end
      end
      SWPC_ST_SERVE: begin
        if (host_cmd_done || (standby && cpu_idle && !host_cmd_req)) begin
          state_next = SWPC_ST_LIGHT;
        end
      end
      SWPC_ST_DEEP: begin
        if (wake_any) begin
          state_next = SWPC_ST_WAKE;
        end
      end
      SWPC_ST_WAKE: begin
        if (pwr_cnt_reg == 8'(SWPC_PWR_UP_CYC - 1)) begin
          state_next = SWPC_ST_ACTIVE;
        end
      end
      default: begin
        state_next = SWPC_ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SWPC_ST_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // power-up settle count after deep sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_cnt_reg <= 8'h00;
    end else if (state_reg == SWPC_ST_WAKE) begin
      pwr_cnt_reg <= pwr_cnt_reg + 8'h01;
    end else begin
      pwr_cnt_reg <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // always-on sleep timer, counts low-frequency ticks down to zero

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lf_prev_reg <= 1'b0;
    end else begin
      lf_prev_reg <= lf_clk;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_reg <= SWPC_TIMEOUT_RESET[TIMER_W-1:0];
    end else if (state_reg != state_next &&
                 (state_next == SWPC_ST_LIGHT || state_next == SWPC_ST_DEEP)) begin
      timer_reg <= timeout_reg;
    end else if ((state_reg == SWPC_ST_LIGHT || state_reg == SWPC_ST_DEEP) && lf_tick && !timer_exp) begin
      timer_reg <= timer_reg - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host interface type, caught once after power-up

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_if_reg <= 2'h0;
      host_if_valid_reg <= 1'b0;
    end else if (host_if_det_valid && !host_if_valid_reg) begin
      host_if_reg <= host_if_det_type;
      host_if_valid_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power and clock outputs

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hf_clk_en <= 1'b1;
      cpu_clk_en <= 1'b1;
      host_if_clk_en <= 1'b1;
      ram_retain <= 1'b1;
      aon_low_supply <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      hf_clk_en <= (state_next == SWPC_ST_ACTIVE) || (state_next == SWPC_ST_SERVE);
      cpu_clk_en <= (state_next == SWPC_ST_ACTIVE) || (state_next == SWPC_ST_SERVE);
      host_if_clk_en <= (state_next != SWPC_ST_DEEP);
      ram_retain <= (state_next != SWPC_ST_DEEP) || ctrl_reg[SWPC_CTRL_RETAIN_BIT];
      aon_low_supply <= (state_next == SWPC_ST_DEEP);
      wake_pulse <= (state_reg != SWPC_ST_ACTIVE) && (state_next == SWPC_ST_ACTIVE) &&
                    (state_reg != SWPC_ST_SERVE);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_if_sel <= 2'h0;
      host_if_sel_valid <= 1'b0;
    end else begin
      host_if_sel <= host_if_valid_reg ? host_if_reg : host_if_det_type;
      host_if_sel_valid <= host_if_valid_reg;
    end
  end

  // per-subsystem power and clock gating
  generate
    for (genvar i = 0; i < N_SUBSYS; i++) begin : g_subsys
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          subsys_pwr_en[i] <= 1'b1;
          subsys_clk_en[i] <= 1'b1;
        end else begin
          subsys_pwr_en[i] <= subsys_en_reg[i] && (state_next != SWPC_ST_DEEP);
          subsys_clk_en[i] <= subsys_en_reg[i] && subsys_busy[i] &&
                              (state_next == SWPC_ST_ACTIVE || state_next == SWPC_ST_SERVE);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle, answer on the second edge

  assign bus_done = (avs_read | avs_write) & ~wait_reg;
  assign wr_en = avs_write & ~wait_reg;
  assign rd_en = avs_read & ~wait_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 1'b1;
    end else if ((avs_read || avs_write) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  assign avs_waitrequest = wait_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else if (avs_read && wait_reg) begin
      case (avs_address)
        SWPC_CTRL_OFS: rdata_reg <= {25'h0, ctrl_reg};
        SWPC_WAKE_EN_OFS: rdata_reg <= {26'h0, wake_en_reg};
        SWPC_TIMEOUT_OFS: rdata_reg <= 32'(timeout_reg);
        SWPC_STATE_OFS: rdata_reg <= {16'h0000, 8'(timer_reg[TIMER_W-1 -: 8]), 2'h0,
                                      host_if_valid_reg, host_if_reg, state_reg};
        SWPC_IRQ_STAT_OFS: rdata_reg <= {26'h0, irq_stat_reg};
        SWPC_IRQ_MASK_OFS: rdata_reg <= {26'h0, irq_mask_reg};
        SWPC_SUBSYS_OFS: rdata_reg <= 32'(subsys_en_reg);
        default: rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign avs_readdata = rdata_reg;

  // control word; the enter bit is a one-cycle request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= SWPC_CTRL_RESET;
      enter_reg <= 1'b0;
    end else begin
      enter_reg <= 1'b0;
      if (wr_en && avs_address == SWPC_CTRL_OFS) begin
        ctrl_reg <= {avs_writedata[6:1], 1'b0};
        enter_reg <= avs_writedata[SWPC_CTRL_ENTER_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_en_reg <= SWPC_WAKE_EN_RESET;
      timeout_reg <= SWPC_TIMEOUT_RESET[TIMER_W-1:0];
      irq_mask_reg <= SWPC_IRQ_MASK_RESET;
      subsys_en_reg <= '1;
    end else if (wr_en) begin
      case (avs_address)
        SWPC_WAKE_EN_OFS: wake_en_reg <= avs_writedata[SWPC_SRC_NUM-1:0];
        SWPC_TIMEOUT_OFS: timeout_reg <= avs_writedata[TIMER_W-1:0];
        SWPC_IRQ_MASK_OFS: irq_mask_reg <= avs_writedata[SWPC_SRC_NUM-1:0];
        SWPC_SUBSYS_OFS: subsys_en_reg <= avs_writedata[N_SUBSYS-1:0];
        default: begin
        end
      endcase
    end
  end

  // sticky wake causes; a read clears only the bits it returned, so no cause is lost
  assign stat_clr = (rd_en && avs_address == SWPC_IRQ_STAT_OFS) ? rdata_reg[SWPC_SRC_NUM-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else begin
      if (rd_en && avs_address == SWPC_IRQ_STAT_OFS) begin
        irq_stat_reg <= (irq_stat_reg & ~stat_clr) | src_allowed;
      end else begin
        irq_stat_reg <= irq_stat_reg | src_allowed;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_reg & ~stat_clr) | src_allowed) & irq_mask_reg);
    end
  end

endmodule // swpc_top
`default_nettype wire

/* core/swpc_pkg.sv */
// swpc_pkg: constants, register map and state type of the sleep and wake power controller
// assumes: a 10 MHz system clock and a 32 kHz low-frequency clock level sampled on it
package swpc_pkg;

  localparam int unsigned SWPC_CLK_HZ = 10_000_000;
  localparam int unsigned SWPC_LF_HZ = 32_768;
  localparam int unsigned SWPC_PWR_UP_NS = 2_000;
  localparam int unsigned SWPC_PWR_UP_CYC_RAW = (SWPC_PWR_UP_NS * (SWPC_CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam int unsigned SWPC_PWR_UP_CYC = (SWPC_PWR_UP_CYC_RAW < 1) ? 1 : SWPC_PWR_UP_CYC_RAW;

  // byte offsets of the avalon register words
  localparam logic [7:0] SWPC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SWPC_WAKE_EN_OFS = 8'h04;
  localparam logic [7:0] SWPC_TIMEOUT_OFS = 8'h08;
  localparam logic [7:0] SWPC_STATE_OFS = 8'h0c;
  localparam logic [7:0] SWPC_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] SWPC_IRQ_MASK_OFS = 8'h14;
  localparam logic [7:0] SWPC_SUBSYS_OFS = 8'h18;

  // control word fields
  localparam int unsigned SWPC_CTRL_ENTER_BIT = 0;
  localparam int unsigned SWPC_CTRL_MODE_LSB = 1;
  localparam int unsigned SWPC_CTRL_RETAIN_BIT = 3;
  localparam int unsigned SWPC_CTRL_AUTO_BIT = 4;
  localparam int unsigned SWPC_CTRL_STANDBY_BIT = 5;
  localparam int unsigned SWPC_CTRL_POL_BIT = 6;
  localparam logic [6:0] SWPC_CTRL_RESET = 7'h00;

  // wake source bit positions, shared by wake enable, irq status and irq mask
  localparam int unsigned SWPC_SRC_TIMER = 0;
  localparam int unsigned SWPC_SRC_GPIO = 1;
  localparam int unsigned SWPC_SRC_COMP = 2;
  localparam int unsigned SWPC_SRC_RTC = 3;
  localparam int unsigned SWPC_SRC_WDT = 4;
  localparam int unsigned SWPC_SRC_HOST = 5;
  localparam int unsigned SWPC_SRC_NUM = 6;
  localparam logic [5:0] SWPC_WAKE_EN_RESET = 6'h3f;
  localparam logic [5:0] SWPC_IRQ_MASK_RESET = 6'h00;
  localparam logic [23:0] SWPC_TIMEOUT_RESET = 24'h008000;

  // sleep target encodings in the control word
  localparam logic [1:0] SWPC_TGT_LIGHT = 2'h1;
  localparam logic [1:0] SWPC_TGT_DEEP = 2'h2;

  typedef enum logic [2:0] {
    SWPC_ST_ACTIVE = 3'b000,
    SWPC_ST_LIGHT = 3'b001,
    SWPC_ST_SERVE = 3'b010,
    SWPC_ST_DEEP = 3'b011,
    SWPC_ST_WAKE = 3'b100
  } swpc_state_type;

endpackage

/* sim/swpc_sva.sv */
// swpc_sva: port assertions for swpc_top
// assumes: one clock domain, rst asynchronous and active high
`timescale 1ns/1ps
`default_nettype none
module swpc_sva #(
  parameter int unsigned N_SUBSYS = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic host_cmd_req,
  input wire logic host_cmd_done,
  input wire logic [N_SUBSYS-1:0] subsys_busy,
  input wire logic hf_clk_en,
  input wire logic cpu_clk_en,
  input wire logic host_if_clk_en,
  input wire logic [N_SUBSYS-1:0] subsys_pwr_en,
  input wire logic [N_SUBSYS-1:0] subsys_clk_en,
  input wire logic ram_retain,
  input wire logic aon_low_supply,
  input wire logic [1:0] host_if_sel,
  input wire logic host_if_sel_valid,
  input wire logic wake_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence ans_s; !avs_waitrequest ##1 avs_waitrequest; endsequence
  sequence lit_req_s; !cpu_clk_en && host_if_clk_en && host_cmd_req; endsequence
  sequence served_s; lit_req_s ##[1:8] (cpu_clk_en && host_cmd_done && !wake_pulse); endsequence
  bus_answer_a: assert property (req_s |=> ans_s) else $error("bus answer late");
  deep_power_a: assert property (aon_low_supply |-> subsys_pwr_en == '0) else $error("powered in deep");
  aon_clock_a: assert property (aon_low_supply |-> !hf_clk_en && !cpu_clk_en) else $error("clock in deep");
  ram_keep_a: assert property (!aon_low_supply |-> ram_retain) else $error("ram dropped");
  hf_gate_a: assert property (!hf_clk_en |-> !cpu_clk_en && subsys_clk_en == '0)
    else $error("clock left on in sleep");
  host_clock_a: assert property (host_if_clk_en != aon_low_supply) else $error("host clock wrong");
  host_wake_a: assert property (lit_req_s |-> ##[1:24] cpu_clk_en) else $error("no host wake");
  regate_a: assert property (served_s |-> ##[1:2] !cpu_clk_en) else $error("clock not regated");
  busy_gate_a: assert property (!$past(rst) |-> (subsys_clk_en & ~$past(subsys_busy)) == '0)
    else $error("idle block clocked");
  sel_hold_a: assert property (host_if_sel_valid |=> host_if_sel_valid && $stable(host_if_sel))
    else $error("host type changed");
  one_exit_a: assert property (wake_pulse |=> !wake_pulse [*3]) else $error("double exit");
endmodule // swpc_sva
bind swpc_top swpc_sva #(.N_SUBSYS(N_SUBSYS)) i_swpc_sva (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .host_cmd_req, .host_cmd_done, .subsys_busy, .hf_clk_en, .cpu_clk_en, .host_if_clk_en, .subsys_pwr_en,
  .subsys_clk_en, .ram_retain, .aon_low_supply, .host_if_sel, .host_if_sel_valid, .wake_pulse);
`default_nettype wire

/* sim/swpc_host_model.sv */
// swpc_host_model: host processor side and the interface type detector
// assumes: cmd_start and going_deep are driven by the bench
`timescale 1ns/1ps
`default_nettype none
module swpc_host_model #(
  parameter logic [1:0] DET_FIRST = 2'h2,
  parameter logic [1:0] DET_LATER = 2'h1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_start,
  input wire logic cpu_clk_en,
  input wire logic going_deep,
  input wire logic aon_low_supply,
  input wire logic irq,
  output logic host_cmd_req,
  output logic host_cmd_done,
  output logic host_if_det_valid,
  output logic [1:0] host_if_det_type,
  output logic irq_seen
);
  logic [3:0] age_reg;
  logic [1:0] hold_reg;
  logic irq_en_reg;
  // a second, different report follows; only the first may be kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age_reg <= 4'h0;
      host_if_det_valid <= 1'b0;
      host_if_det_type <= 2'h0;
    end else begin
      if (age_reg != 4'hf) age_reg <= age_reg + 4'h1;
      host_if_det_valid <= (age_reg == 4'h2) || (age_reg == 4'h9);
      host_if_det_type <= (age_reg == 4'h2) ? DET_FIRST : DET_LATER;
    end
  end
  // command held until served, done one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_cmd_req <= 1'b0;
      host_cmd_done <= 1'b0;
      hold_reg <= 2'h0;
    end else begin
      host_cmd_done <= 1'b0;
      if (cmd_start) host_cmd_req <= 1'b1;
      else if (host_cmd_req && cpu_clk_en) begin
        hold_reg <= hold_reg + 2'h1;
        if (hold_reg == 2'h2) begin
          host_cmd_req <= 1'b0;
          host_cmd_done <= 1'b1;
          hold_reg <= 2'h0;
        end
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) irq_en_reg <= 1'b0;
    else if (going_deep) irq_en_reg <= 1'b0;
    else if (host_cmd_done && !aon_low_supply) irq_en_reg <= 1'b1;
  end
  assign irq_seen = irq && irq_en_reg;
endmodule // swpc_host_model
`default_nettype wire

/* sim/testbench.sv */
// testbench: register, deep and light sleep sequences for swpc_top
// assumes: swpc_top, swpc_host_model and swpc_sva compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, lf_clk = 1'b0, gpio_wake = 1'b0;
  logic comp_event = 1'b0, rtc_timeout = 1'b0, wdt_irq = 1'b0, cpu_idle = 1'b0, cmd_start = 1'b0;
  logic going_deep = 1'b0, avs_waitrequest, irq, host_cmd_req, host_cmd_done, host_if_det_valid, irq_seen;
  logic hf_clk_en, cpu_clk_en, host_if_clk_en, ram_retain, aon_low_supply, host_if_sel_valid, wake_pulse;
  logic [1:0] host_if_det_type, host_if_sel;
  logic [3:0] subsys_pwr_en, subsys_clk_en, subsys_busy = 4'h5;
  logic [7:0] avs_address = 8'h00, lf_cnt = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rv [6] = '{32'h0, 32'h3f, 32'h8000, 32'h0, 32'hf, 32'h0};
  int fails = 0, checks_done = 0, pulses = 0, p0;
  swpc_top i_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .irq, .lf_clk, .gpio_wake, .comp_event, .rtc_timeout, .wdt_irq, .host_cmd_req,
    .host_cmd_done, .cpu_idle, .subsys_busy, .host_if_det_valid, .host_if_det_type, .hf_clk_en, .cpu_clk_en,
    .host_if_clk_en, .subsys_pwr_en, .subsys_clk_en, .ram_retain, .aon_low_supply, .host_if_sel,
    .host_if_sel_valid, .wake_pulse);
  swpc_host_model i_host (.clk, .rst, .cmd_start, .cpu_clk_en, .going_deep, .aon_low_supply, .irq,
    .host_cmd_req, .host_cmd_done, .host_if_det_valid, .host_if_det_type, .irq_seen);
  always #50 clk = ~clk;
  // low-frequency clock of about 32 kHz
  always @(posedge clk) begin
    lf_cnt <= (lf_cnt == 8'h97) ? 8'h00 : lf_cnt + 8'h01;
    if (lf_cnt == 8'h97) lf_clk <= ~lf_clk;
    if (wake_pulse === 1'b1) pulses <= pulses + 1;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) check(32'h0, 32'h1);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  // 0 deep, 1 high clock gated, 2 processor clock on, 3 wake pulse
  task automatic wt(input int k, input int lim);
    int n;
    logic [3:0] v;
    n = 0;
    v = {wake_pulse, cpu_clk_en, !hf_clk_en, aon_low_supply};
    while (v[k] !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
      v = {wake_pulse, cpu_clk_en, !hf_clk_en, aon_low_supply};
    end
    if (n == lim) check(32'(k), 32'hff);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b1, 8'h1c, 32'hffffffff);
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 32'h0);
      check(rd, rv[i]);
    end
    check(32'({host_if_sel_valid, host_if_sel}), 32'h6);
    check(32'(subsys_clk_en), 32'h5);
    bus(1'b1, 8'h18, 32'h3);
    @(posedge clk);
    check(32'(subsys_pwr_en), 32'h3);
    subsys_busy <= 4'h6;
    repeat (2) @(posedge clk);
    check(32'(subsys_clk_en), 32'h2);
    $display("test registers done");
    bus(1'b1, 8'h08, 32'h2);
    bus(1'b1, 8'h14, 32'h3f);
    for (int s = 0; s < 5; s++) begin
      bus(1'b1, 8'h04, 32'h1 << s);
      going_deep <= 1'b1;
      bus(1'b1, 8'h00, 32'h45 | (32'(s[0]) << 3));
      wt(0, 40);
      going_deep <= 1'b0;
      check(32'(subsys_pwr_en), 32'h0);
      check(32'({host_if_clk_en, ram_retain}), 32'(s[0]));
      {wdt_irq, rtc_timeout, comp_event, gpio_wake} <= 4'((5'h1 << s) >> 1);
      wt(3, 1000);
      {wdt_irq, rtc_timeout, comp_event, gpio_wake} <= 4'h0;
      check(32'(irq), 32'h1);
      check(32'(irq_seen), 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      check(rd, 32'h1 << s);
      bus(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      check(32'(irq), 32'h0);
    end
    $display("test deep wake done");
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h04, 32'h3f);
    bus(1'b1, 8'h08, 32'hffffff);
    bus(1'b1, 8'h00, 32'h45);
    wt(0, 40);
    p0 = pulses;
    {wdt_irq, rtc_timeout, comp_event, gpio_wake} <= 4'hf;
    wt(3, 100);
    {wdt_irq, rtc_timeout, comp_event, gpio_wake} <= 4'h0;
    repeat (30) @(posedge clk);
    check(32'(pulses - p0), 32'h1);
    check(32'(irq), 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h1e);
    bus(1'b0, 8'h0c, 32'h0);
    check(32'(rd[5:0]), 32'h30);
    $display("test joint wake done");
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h00, 32'h3);
    wt(1, 40);
    check(32'({cpu_clk_en, host_if_clk_en}), 32'h1);
    cmd_start <= 1'b1;
    @(posedge clk);
    cmd_start <= 1'b0;
    wt(2, 30);
    wt(1, 20);
    bus(1'b0, 8'h0c, 32'h0);
    check(32'(rd[2:0]), 32'h1);
    gpio_wake <= 1'b1;
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b0, 8'h10, 32'h0);
    gpio_wake <= 1'b0;
    wt(3, 40);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h2);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h08, 32'h2);
    cpu_idle <= 1'b1;
    bus(1'b1, 8'h00, 32'h12);
    wt(1, 40);
    cpu_idle <= 1'b0;
    bus(1'b1, 8'h00, 32'h0);
    wt(3, 1000);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h1);
    $display("test light wake done");
    bus(1'b1, 8'h00, 32'h23);
    wt(1, 40);
    p0 = pulses;
    wt(2, 1000);
    bus(1'b0, 8'h0c, 32'h0);
    check(32'(rd[2:0]), 32'h2);
    cpu_idle <= 1'b1;
    wt(1, 20);
    check(32'(pulses - p0), 32'h0);
    $display("test standby done");
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
